/* File: rtl/bamd_pkg.sv */
// Constants and types for the buffer and address map decoder
package bamd_pkg;
  // Flash geometry and bank selection
  localparam int unsigned FLASH_AW    = 20;
  localparam logic [5:0]  FIXED_PAGE  = 6'h00;
  localparam logic [5:0]  BANK_RESET  = 6'h01;
  // Data-space internal register ranges
  localparam logic [15:0] RT_LO  = 16'h7f00;
  localparam logic [15:0] RT_HI  = 16'h7f0f;
  localparam logic [15:0] CFG_LO = 16'h7f10;
  localparam logic [15:0] CFG_HI = 16'h7f1f;
  localparam logic [15:0] PWR_LO = 16'h7f20;
  localparam logic [15:0] PWR_HI = 16'h7f2f;
  localparam logic [15:0] BM_LO  = 16'h7f50;
  localparam logic [15:0] BM_HI  = 16'h7f6f;
  localparam logic [15:0] HB_LO  = 16'h7f70;
  localparam logic [15:0] HB_HI  = 16'h7f7f;
  localparam logic [15:0] SE_LO  = 16'h7f80;
  localparam logic [15:0] SE_HI  = 16'h7f9f;
  localparam logic [15:0] BUF_DATA_ADDR = 16'h6000;
  localparam logic [15:0] HMEM_LO = 16'h5000;
  localparam logic [15:0] HMEM_HI = 16'h5fff;
  localparam logic [15:0] HIO_LO  = 16'h4000;
  localparam logic [15:0] HIO_HI  = 16'h40ff;
  localparam logic [15:0] CORE_HI = 16'h00ff;
  // Region select bit positions
  localparam int unsigned SEL_RUNTIME  = 0;
  localparam int unsigned SEL_CONFIG   = 1;
  localparam int unsigned SEL_POWER    = 2;
  localparam int unsigned SEL_BUF_MGR  = 3;
  localparam int unsigned SEL_HOST_REG = 4;
  localparam int unsigned SEL_SERIAL   = 5;
  localparam int unsigned SEL_BUF_DATA = 6;
  localparam int unsigned SEL_HOST_MEM = 7;
  localparam int unsigned SEL_HOST_IO  = 8;
  localparam int unsigned SEL_CORE     = 9;
  localparam int unsigned N_SEL        = 10;
  // Packet buffer geometry and queue limits
  localparam int unsigned NUM_PAGES   = 32;
  localparam int unsigned PAGE_BYTES  = 128;
  localparam int unsigned MAX_PAGES   = 10;
  localparam int unsigned WIN_PAGES   = 8;
  localparam int unsigned NUM_EP      = 16;
  localparam logic [2:0]  TX_DEPTH    = 3'd5;
  localparam logic [4:0]  RX_DEPTH    = 5'd16;
  localparam int unsigned BUF_BYTES   = NUM_PAGES * PAGE_BYTES;
  localparam logic [1:0]  HDR_LAST    = 2'd3;
  // Buffer RAM requesters: core, four host DMA channels, packet DMA
  localparam int unsigned N_EXT_REQ   = 5;
  localparam int unsigned N_REQ       = 6;
  localparam int unsigned USB_DMA_REQ = 5;
  // State types
  typedef enum logic [0:0] {AL_IDLE, AL_SCAN} bamd_alloc_e;
  typedef enum logic [1:0] {HD_IDLE, HD_WRITE, HD_NOTIFY} bamd_hdr_e;
endpackage : bamd_pkg

/* File: rtl/bamd_arbiter.sv */
// Round-robin arbiter for the single-ported packet buffer
module bamd_arbiter #(
  parameter int unsigned N = 6
) (
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic [N-1:0] req,
  output logic      [N-1:0] pick
);
  logic [N-1:0] last_q;
  logic [N-1:0] last_d;
  logic [N-1:0] elig;
  int unsigned  ptr_q;
  int unsigned  ptr_d;

  // One winner per cycle; the requester served last cycle sits out once
  always_comb begin
    pick   = '0;
    elig   = req & ~last_q;
    ptr_d  = ptr_q;
    for (int unsigned k = 0; k < N; k++) begin
      if (pick == '0 && elig[(ptr_q + k) % N]) begin
        pick[(ptr_q + k) % N] = 1'b1;
        ptr_d = (ptr_q + k + 1) % N;
      end
    end
    last_d = pick;
  end

  // Pointer and last-grant registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_q  <= 0;
      last_q <= '0;
    end else begin
      ptr_q  <= ptr_d;
      last_q <= last_d;
    end
  end
endmodule : bamd_arbiter

/* File: rtl/bamd_top.sv */
// Address map decoder and packet buffer page manager
// How it works
// - Low 16K code always hits flash 0-3FFF
// - Code 4000-7FFF windows onto selected 16K page
// - Bank select resets to flash page 1
// - 8000-BFFF fixed page, C000-FFFF banked page
// - Runtime, config, power ranges decode internally
// - Buffer, host-bus, serial ranges decode internally
// - Internal access drives address, strobes stay idle
// - DMA 8000-FFFF maps 32 packet 1K windows
// - DMA 0000-7FFF forwards to external memory
// - Packet pages appear contiguous to host DMA
// - Buffer is 32 pages of 128 bytes
// - Allocation spans at most ten pages
// - Sixteen transmit queues, five packets each
// - Receive queue holds 16, then backs off
// - Arbiter shares buffer among all requesters
// - Packet DMA writes status header, then notifies
// - Flash strobes are active low
module bamd_top (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] mcu_addr,
  input  wire logic        mcu_code,
  input  wire logic        mcu_rd,
  input  wire logic        mcu_wr,
  input  wire logic        bank_wr,
  input  wire logic [5:0]  bank_wdata,
  output logic      [5:0]  bank,
  output logic      [19:0] flash_addr,
  output logic             flash_read_strobe_n,
  output logic             flash_write_strobe_n,
  output logic      [9:0]  region_sel,
  input  wire logic        dma_valid,
  input  wire logic [15:0] dma_addr,
  output logic             dma_buf_hit,
  output logic             dma_buf_miss,
  output logic      [11:0] dma_buf_addr,
  output logic             dma_ext_sel,
  output logic      [14:0] dma_ext_addr,
  input  wire logic        alloc_req,
  input  wire logic [4:0]  alloc_pnr,
  input  wire logic [3:0]  alloc_len,
  output logic             alloc_done,
  output logic             alloc_fail,
  input  wire logic        rel_req,
  input  wire logic [4:0]  rel_pnr,
  output logic      [5:0]  free_pages,
  input  wire logic        tx_push,
  input  wire logic        tx_pop,
  input  wire logic [3:0]  tx_ep,
  output logic      [15:0] tx_full,
  input  wire logic        rx_pop,
  output logic      [4:0]  rx_count,
  output logic             rx_backoff,
  input  wire logic        rx_done,
  input  wire logic [4:0]  rx_pnr,
  input  wire logic [10:0] rx_frame,
  input  wire logic [3:0]  rx_ep,
  input  wire logic [10:0] rx_bytes,
  output logic             rx_arrived,
  input  wire logic [4:0]  buf_req,
  input  wire logic [4:0]  buf_we,
  input  wire logic [59:0] buf_addr,
  input  wire logic [39:0] buf_wdata,
  output logic      [4:0]  buf_gnt,
  output logic      [7:0]  buf_rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // ---------------- Controller address decode ----------------
  logic [5:0]  bank_q, bank_d;
  logic [19:0] fa_q, fa_d;
  logic        frd_n_q, frd_n_d, fwr_n_q, fwr_n_d;
  logic [9:0]  sel_q, sel_d;
  logic        to_flash;

  // Flash window select and region decode
  always_comb begin
    bank_d   = bank_wr ? bank_wdata : bank_q;
    to_flash = mcu_code | mcu_addr[15];
    sel_d    = '0;
    if (to_flash) begin
      // Bit 14 picks banked page over fixed page
      fa_d = mcu_addr[14] ? {bank_q, mcu_addr[13:0]}
                          : {bamd_pkg::FIXED_PAGE, mcu_addr[13:0]};
    end else begin
      fa_d = {4'h0, mcu_addr};
    end
    frd_n_d = !(mcu_rd && to_flash);
    fwr_n_d = !(mcu_wr && to_flash);
    if (!to_flash && (mcu_rd || mcu_wr)) begin
      if (mcu_addr >= bamd_pkg::RT_LO && mcu_addr <= bamd_pkg::RT_HI)
        sel_d[bamd_pkg::SEL_RUNTIME] = 1'b1;
      if (mcu_addr >= bamd_pkg::CFG_LO && mcu_addr <= bamd_pkg::CFG_HI)
        sel_d[bamd_pkg::SEL_CONFIG] = 1'b1;
      if (mcu_addr >= bamd_pkg::PWR_LO && mcu_addr <= bamd_pkg::PWR_HI)
        sel_d[bamd_pkg::SEL_POWER] = 1'b1;
      if (mcu_addr >= bamd_pkg::BM_LO && mcu_addr <= bamd_pkg::BM_HI)
        sel_d[bamd_pkg::SEL_BUF_MGR] = 1'b1;
      if (mcu_addr >= bamd_pkg::HB_LO && mcu_addr <= bamd_pkg::HB_HI)
        sel_d[bamd_pkg::SEL_HOST_REG] = 1'b1;
      if (mcu_addr >= bamd_pkg::SE_LO && mcu_addr <= bamd_pkg::SE_HI)
        sel_d[bamd_pkg::SEL_SERIAL] = 1'b1;
      if (mcu_addr == bamd_pkg::BUF_DATA_ADDR)
        sel_d[bamd_pkg::SEL_BUF_DATA] = 1'b1;
      if (mcu_addr >= bamd_pkg::HMEM_LO && mcu_addr <= bamd_pkg::HMEM_HI)
        sel_d[bamd_pkg::SEL_HOST_MEM] = 1'b1;
      if (mcu_addr >= bamd_pkg::HIO_LO && mcu_addr <= bamd_pkg::HIO_HI)
        sel_d[bamd_pkg::SEL_HOST_IO] = 1'b1;
      if (mcu_addr <= bamd_pkg::CORE_HI)
        sel_d[bamd_pkg::SEL_CORE] = 1'b1;
    end
  end

  // Decode registers; bank starts on page 1
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_q  <= bamd_pkg::BANK_RESET;
      fa_q    <= '0;
      frd_n_q <= 1'b1;
      fwr_n_q <= 1'b1;
      sel_q   <= '0;
    end else begin
      bank_q  <= bank_d;
      fa_q    <= fa_d;
      frd_n_q <= frd_n_d;
      fwr_n_q <= fwr_n_d;
      sel_q   <= sel_d;
    end
  end

  // ---------------- Page table and allocation ----------------
  logic [4:0]  tab_q [bamd_pkg::NUM_PAGES][bamd_pkg::MAX_PAGES];
  logic [4:0]  tab_d [bamd_pkg::NUM_PAGES][bamd_pkg::MAX_PAGES];
  logic [3:0]  cnt_q [bamd_pkg::NUM_PAGES];
  logic [3:0]  cnt_d [bamd_pkg::NUM_PAGES];
  logic [31:0] free_q, free_d;
  logic [4:0]  scan_q, scan_d, apnr_q, apnr_d;
  logic [3:0]  got_q, got_d, alen_q, alen_d;
  logic        adone_q, adone_d, afail_q, afail_d;
  logic [5:0]  nfree_q, nfree_d;
  bamd_pkg::bamd_alloc_e al_q, al_d;

  // Allocation scans free pages one per cycle; release frees at once
  always_comb begin
    tab_d   = tab_q;
    cnt_d   = cnt_q;
    free_d  = free_q;
    scan_d  = scan_q;
    apnr_d  = apnr_q;
    got_d   = got_q;
    alen_d  = alen_q;
    al_d    = al_q;
    adone_d = 1'b0;
    afail_d = 1'b0;
    case (al_q)
      bamd_pkg::AL_IDLE: begin
        if (alloc_req) begin
          if (alloc_len == 4'h0 || alloc_len > 4'(bamd_pkg::MAX_PAGES) ||
              cnt_q[alloc_pnr] != 4'h0 ||
              {2'b00, alloc_len} > nfree_q) begin
            afail_d = 1'b1;
          end else begin
            apnr_d = alloc_pnr;
            alen_d = alloc_len;
            scan_d = '0;
            got_d  = '0;
            al_d   = bamd_pkg::AL_SCAN;
          end
        end else if (rel_req) begin
          for (int unsigned i = 0; i < bamd_pkg::MAX_PAGES; i++) begin
            if (4'(i) < cnt_q[rel_pnr])
              free_d[tab_q[rel_pnr][i]] = 1'b1;
          end
          cnt_d[rel_pnr] = 4'h0;
        end
      end
      bamd_pkg::AL_SCAN: begin
        if (free_q[scan_q]) begin
          tab_d[apnr_q][got_q] = scan_q;
          free_d[scan_q] = 1'b0;
          got_d = got_q + 4'h1;
          if (got_q + 4'h1 == alen_q) begin
            cnt_d[apnr_q] = alen_q;
            adone_d = 1'b1;
            al_d = bamd_pkg::AL_IDLE;
          end
        end
        scan_d = scan_q + 5'h1;
      end
      default: al_d = bamd_pkg::AL_IDLE;
    endcase
    nfree_d = 6'($countones(free_d));
  end

  // Page manager registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tab_q   <= '{default: '{default: 5'h00}};
      cnt_q   <= '{default: 4'h0};
      free_q  <= '1;
      nfree_q <= 6'(bamd_pkg::NUM_PAGES);
      scan_q  <= '0;
      apnr_q  <= '0;
      got_q   <= '0;
      alen_q  <= '0;
      adone_q <= 1'b0;
      afail_q <= 1'b0;
      al_q    <= bamd_pkg::AL_IDLE;
    end else begin
      tab_q   <= tab_d;
      cnt_q   <= cnt_d;
      free_q  <= free_d;
      nfree_q <= nfree_d;
      scan_q  <= scan_d;
      apnr_q  <= apnr_d;
      got_q   <= got_d;
      alen_q  <= alen_d;
      adone_q <= adone_d;
      afail_q <= afail_d;
      al_q    <= al_d;
    end
  end

  // ---------------- Host-bus DMA address map ----------------
  logic        dhit_q, dhit_d, dmiss_q, dmiss_d, dext_q, dext_d;
  logic [11:0] dbuf_q, dbuf_d;
  logic [14:0] dea_q, dea_d;
  logic [4:0]  win_pnr;
  logic [2:0]  win_pg;

  // Packet windows gather scattered pages into one block
  always_comb begin
    win_pnr = dma_addr[14:10];
    win_pg  = dma_addr[9:7];
    dhit_d  = 1'b0;
    dmiss_d = 1'b0;
    dext_d  = 1'b0;
    dbuf_d  = dbuf_q;
    dea_d   = dea_q;
    if (dma_valid && dma_addr[15]) begin
      if ({1'b0, win_pg} < cnt_q[win_pnr]) begin
        dhit_d = 1'b1;
        dbuf_d = {tab_q[win_pnr][win_pg], dma_addr[6:0]};
      end else begin
        dmiss_d = 1'b1;
      end
    end else if (dma_valid) begin
      dext_d = 1'b1;
      dea_d  = dma_addr[14:0];
    end
  end

  // Host DMA translation registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dhit_q  <= 1'b0;
      dmiss_q <= 1'b0;
      dext_q  <= 1'b0;
      dbuf_q  <= '0;
      dea_q   <= '0;
    end else begin
      dhit_q  <= dhit_d;
      dmiss_q <= dmiss_d;
      dext_q  <= dext_d;
      dbuf_q  <= dbuf_d;
      dea_q   <= dea_d;
    end
  end

  // ---------------- Transmit and receive queues ----------------
  logic [2:0]  txc_q [bamd_pkg::NUM_EP];
  logic [2:0]  txc_d [bamd_pkg::NUM_EP];
  logic [15:0] txf_q, txf_d;
  logic [4:0]  rxc_q, rxc_d;
  logic        rxb_q, rxb_d, rx_push;

  // Occupancy counts; a full queue ignores further pushes
  always_comb begin
    txc_d = txc_q;
    if (tx_push && !tx_pop && txc_q[tx_ep] != bamd_pkg::TX_DEPTH)
      txc_d[tx_ep] = txc_q[tx_ep] + 3'h1;
    else if (tx_pop && !tx_push && txc_q[tx_ep] != 3'h0)
      txc_d[tx_ep] = txc_q[tx_ep] - 3'h1;
    for (int unsigned e = 0; e < bamd_pkg::NUM_EP; e++)
      txf_d[e] = (txc_d[e] == bamd_pkg::TX_DEPTH);
    rxc_d = rxc_q;
    if (rx_push && !rx_pop && rxc_q != bamd_pkg::RX_DEPTH)
      rxc_d = rxc_q + 5'h1;
    else if (rx_pop && !rx_push && rxc_q != 5'h0)
      rxc_d = rxc_q - 5'h1;
    rxb_d = (rxc_d == bamd_pkg::RX_DEPTH);
  end

  // Queue registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      txc_q <= '{default: 3'h0};
      txf_q <= '0;
      rxc_q <= '0;
      rxb_q <= 1'b0;
    end else begin
      txc_q <= txc_d;
      txf_q <= txf_d;
      rxc_q <= rxc_d;
      rxb_q <= rxb_d;
    end
  end

  // ---------------- Received packet status header ----------------
  bamd_pkg::bamd_hdr_e hd_q, hd_d;
  logic [1:0]  hidx_q, hidx_d;
  logic [31:0] hword_q, hword_d;
  logic [4:0]  hpnr_q, hpnr_d;
  logic        arr_q, arr_d;
  logic [5:0]  pick;
  logic [11:0] hdr_addr;

  // Write four header bytes into the packet's first page, then notify
  always_comb begin
    hd_d     = hd_q;
    hidx_d   = hidx_q;
    hword_d  = hword_q;
    hpnr_d   = hpnr_q;
    arr_d    = 1'b0;
    rx_push  = 1'b0;
    hdr_addr = {tab_q[hpnr_q][0], 5'h00, hidx_q};
    case (hd_q)
      bamd_pkg::HD_IDLE: begin
        if (rx_done) begin
          hpnr_d  = rx_pnr;
          hword_d = {5'h00, rx_bytes, 1'b0, rx_ep, rx_frame};
          hidx_d  = '0;
          hd_d    = bamd_pkg::HD_WRITE;
        end
      end
      bamd_pkg::HD_WRITE: begin
        if (pick[bamd_pkg::USB_DMA_REQ]) begin
          hidx_d = hidx_q + 2'h1;
          if (hidx_q == bamd_pkg::HDR_LAST)
            hd_d = bamd_pkg::HD_NOTIFY;
        end
      end
      bamd_pkg::HD_NOTIFY: begin
        arr_d   = 1'b1;
        rx_push = 1'b1;
        hd_d    = bamd_pkg::HD_IDLE;
      end
      default: hd_d = bamd_pkg::HD_IDLE;
    endcase
  end

  // Header engine registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hd_q    <= bamd_pkg::HD_IDLE;
      hidx_q  <= '0;
      hword_q <= '0;
      hpnr_q  <= '0;
      arr_q   <= 1'b0;
    end else begin
      hd_q    <= hd_d;
      hidx_q  <= hidx_d;
      hword_q <= hword_d;
      hpnr_q  <= hpnr_d;
      arr_q   <= arr_d;
    end
  end

  // ---------------- Shared buffer RAM ----------------
  logic [7:0]  ram [bamd_pkg::BUF_BYTES];
  logic [5:0]  all_req, gnt_q;
  logic [7:0]  rd_q;
  logic [11:0] sel_addr;
  logic [7:0]  sel_wdata;
  logic        sel_we;

  assign all_req = {hd_q == bamd_pkg::HD_WRITE, buf_req};

  bamd_arbiter #(.N(bamd_pkg::N_REQ)) u_arb (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .req     (all_req),
    .pick    (pick)
  );

  // Steer the winning requester onto the single RAM port
  always_comb begin
    sel_addr  = hdr_addr;
    sel_wdata = hword_q[8*hidx_q +: 8];
    sel_we    = pick[bamd_pkg::USB_DMA_REQ];
    for (int unsigned r = 0; r < bamd_pkg::N_EXT_REQ; r++) begin
      if (pick[r]) begin
        sel_addr  = buf_addr[12*r +: 12];
        sel_wdata = buf_wdata[8*r +: 8];
        sel_we    = buf_we[r];
      end
    end
  end

  // RAM access and grant registers
  always_ff @(posedge ref_clk) begin
    if (pick != '0 && sel_we)
      ram[sel_addr] <= sel_wdata;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gnt_q <= '0;
      rd_q  <= '0;
    end else begin
      gnt_q <= pick;
      rd_q  <= ram[sel_addr];
    end
  end

  // Outputs straight from registers
  assign bank                 = bank_q;
  assign flash_addr           = fa_q;
  assign flash_read_strobe_n  = frd_n_q;
  assign flash_write_strobe_n = fwr_n_q;
  assign region_sel           = sel_q;
  assign dma_buf_hit          = dhit_q;
  assign dma_buf_miss         = dmiss_q;
  assign dma_buf_addr         = dbuf_q;
  assign dma_ext_sel          = dext_q;
  assign dma_ext_addr         = dea_q;
  assign alloc_done           = adone_q;
  assign alloc_fail           = afail_q;
  assign free_pages           = nfree_q;
  assign tx_full              = txf_q;
  assign rx_count             = rxc_q;
  assign rx_backoff           = rxb_q;
  assign rx_arrived           = arr_q;
  assign buf_gnt              = gnt_q[4:0];
  assign buf_rdata            = rd_q;

  // ---------------- Checks ----------------
  logic bank_seen_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) bank_seen_q <= 1'b0;
    else if (bank_wr) bank_seen_q <= 1'b1;
  end

  sequence s_hdr_start;
    hd_q == bamd_pkg::HD_IDLE && rx_done;
  endsequence
  sequence s_hdr_notify;
    ##[6:60] rx_arrived;
  endsequence

  chk_low_fixed: assert property (
    mcu_code && mcu_addr[15:14] == 2'b00 |=>
      flash_addr == {6'h00, $past(mcu_addr[13:0])})
    else $error("low code page not fixed");
  chk_bank_window: assert property (
    mcu_code && mcu_addr[15:14] == 2'b01 |=>
      flash_addr == {$past(bank_q), $past(mcu_addr[13:0])})
    else $error("code window misses bank");
  chk_bank_reset: assert property (
    !bank_seen_q |-> bank == 6'h01)
    else $error("bank not at reset page");
  chk_upper_map: assert property (
    mcu_addr[15] |=> flash_addr[19:14] ==
      ($past(mcu_addr[14]) ? $past(bank_q) : 6'h00))
    else $error("upper half mapped wrong");
  chk_int_strobes: assert property (
    !mcu_code && !mcu_addr[15] && (mcu_rd || mcu_wr) |=>
      flash_read_strobe_n && flash_write_strobe_n &&
      flash_addr == {4'h0, $past(mcu_addr)})
    else $error("strobe on internal access");
  chk_reg_select: assert property (
    !mcu_code && mcu_rd && mcu_addr[15:4] == 12'h7f2 |=>
      region_sel == 10'h004)
    else $error("power range not decoded");
  chk_serial_sel: assert property (
    !mcu_code && mcu_wr && mcu_addr[15:5] == 11'h3fc |=>
      region_sel == 10'h020)
    else $error("serial range not decoded");
  chk_dma_ext: assert property (
    dma_valid && !dma_addr[15] |=>
      dma_ext_sel && dma_ext_addr == $past(dma_addr[14:0]) &&
      !dma_buf_hit)
    else $error("external window wrong");
  chk_dma_window: assert property (
    dma_valid && dma_addr[15] |=> dma_buf_hit != dma_buf_miss &&
      (!dma_buf_hit || dma_buf_addr[6:0] == $past(dma_addr[6:0])))
    else $error("packet window wrong");
  chk_alloc_limit: assert property (
    al_q == bamd_pkg::AL_IDLE && alloc_req && alloc_len > 4'ha |=>
      alloc_fail)
    else $error("oversize allocation taken");
  chk_rx_backoff: assert property (
    rx_count == 5'd16 |-> rx_backoff)
    else $error("no back-off when full");
  chk_one_grant: assert property (
    $onehot0(gnt_q) && (gnt_q & $past(gnt_q)) == 6'h00)
    else $error("grant not exclusive");
  chk_hdr_notify: assert property (
    s_hdr_start |-> s_hdr_notify)
    else $error("header not followed by notify");
endmodule : bamd_top

/* File: sim/bamd_mcu_model.sv */
// Controller core model: external accesses and bank loads
module bamd_mcu_model (
  input  wire logic        ref_clk,
  output logic      [15:0] mcu_addr,
  output logic             mcu_code,
  output logic             mcu_rd,
  output logic             mcu_wr,
  output logic             bank_wr,
  output logic      [5:0]  bank_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {mcu_addr, mcu_code, mcu_rd, mcu_wr, bank_wr, bank_wdata} = '0;
  // One access held for one cycle, launched at the falling edge
  task automatic access(input logic [15:0] a, input logic c, input logic w);
    mcu_addr = a;
    mcu_code = c;
    mcu_rd   = !w;
    mcu_wr   = w;
    @(negedge ref_clk);
  endtask : access
  // Bank load pulse; the idle bus never shows a stale address
  task automatic load_bank(input logic [5:0] b);
    {mcu_rd, mcu_wr} = 2'b00;
    mcu_addr   = ~mcu_addr;
    bank_wr    = 1'b1;
    bank_wdata = b;
    @(negedge ref_clk);
    bank_wr    = 1'b0;
    bank_wdata = ~b;
  endtask : load_bank
endmodule : bamd_mcu_model

/* File: sim/bamd_top_bench.sv */
// Self-checking bench for the address map decoder and page manager
module bamd_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, reset_n, mcu_code, mcu_rd, mcu_wr, bank_wr;
  logic [15:0] mcu_addr, dma_addr, tx_full;
  logic [5:0]  bank_wdata, bank, free_pages;
  logic [19:0] flash_addr;
  logic        flash_read_strobe_n, flash_write_strobe_n, dma_valid;
  logic [9:0]  region_sel;
  logic        dma_buf_hit, dma_buf_miss, dma_ext_sel, alloc_req, rel_req;
  logic [11:0] dma_buf_addr;
  logic [14:0] dma_ext_addr;
  logic        alloc_done, alloc_fail, tx_push, tx_pop, rx_pop, rx_backoff;
  logic [4:0]  alloc_pnr, rel_pnr, rx_count, rx_pnr, buf_req, buf_we, buf_gnt;
  logic [3:0]  alloc_len, tx_ep, rx_ep;
  logic        rx_done, rx_arrived;
  logic [10:0] rx_frame, rx_bytes;
  logic [59:0] buf_addr;
  logic [39:0] buf_wdata;
  logic [7:0]  buf_rdata;
  int          num_errors = 0;
  int          samples_checked = 0;
  bamd_top dut_u (.*);
  bamd_mcu_model mcu_u (.*);
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;
  // Compare and count
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("compared %0d, wrong %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // One controller access, then flash bus and region select
  task automatic dec(input logic [15:0] a, input logic c, input logic w,
                     input logic [19:0] fa, input logic [9:0] rs);
    logic quiet;
    quiet = !c && a < 16'h8000;
    mcu_u.access(a, c, w);
    check(flash_addr, fa);
    check({flash_read_strobe_n, flash_write_strobe_n},
          quiet ? 2'b11 : {w, !w});
    check(region_sel, rs);
  endtask : dec
  task automatic test_decode();
    check(bank, 20'h01);
    dec(16'h4123, 1, 0, 20'h04123, 0);
    dec(16'h3abc, 1, 0, 20'h03abc, 0);
    dec(16'h8005, 0, 1, 20'h00005, 0);
    mcu_u.load_bank(6'h3f);
    check(bank, 20'h3f);
    dec(16'h0010, 1, 0, 20'h00010, 0);
    dec(16'h7fff, 1, 0, 20'hfffff, 0);
    dec(16'hc001, 0, 0, 20'hfc001, 0);
    dec(16'hbfff, 1, 1, 20'h03fff, 0);
    dec(16'h7f00, 0, 0, 20'h07f00, 10'h001);
    dec(16'h7f1f, 0, 1, 20'h07f1f, 10'h002);
    dec(16'h7f2f, 0, 0, 20'h07f2f, 10'h004);
    dec(16'h7f50, 0, 1, 20'h07f50, 10'h008);
    dec(16'h7f7f, 0, 0, 20'h07f7f, 10'h010);
    dec(16'h7f9f, 0, 0, 20'h07f9f, 10'h020);
    dec(16'h6000, 0, 1, 20'h06000, 10'h040);
    dec(16'h5fff, 0, 0, 20'h05fff, 10'h080);
    dec(16'h40ff, 0, 0, 20'h040ff, 10'h100);
    dec(16'h0005, 0, 0, 20'h00005, 10'h200);
    dec(16'h7f30, 0, 0, 20'h07f30, 0);
    $display("decode test done");
  endtask : test_decode
  // Host-bus DMA lookup; valid stays up between calls
  task automatic dma(input logic [15:0] a, input logic [2:0] flags,
                     input logic [11:0] ba);
    dma_valid = 1'b1;
    dma_addr  = a;
    @(negedge ref_clk);
    check({dma_buf_hit, dma_buf_miss, dma_ext_sel}, flags);
    if (flags[2]) check(dma_buf_addr, ba);
    if (flags[0]) check(dma_ext_addr, a[14:0]);
  endtask : dma
  // Allocation request, its answer, then a quiet cycle
  task automatic alloc(input logic [4:0] p, input logic [3:0] n,
                       input logic ok, input logic [5:0] left);
    alloc_req = 1'b1;
    alloc_pnr = p;
    alloc_len = n;
    @(negedge ref_clk);
    alloc_req = 1'b0;
    for (int i = 0; i < 40 && !alloc_done && !alloc_fail; i++)
      @(negedge ref_clk);
    check({alloc_done, alloc_fail}, {ok, !ok});
    check(free_pages, left);
    @(negedge ref_clk);
  endtask : alloc
  // Pages ascend from 0; windows show them contiguous, then release
  task automatic test_dma();
    alloc(5'd3, 4'd2, 1'b1, 6'd30);
    alloc(5'd4, 4'd10, 1'b1, 6'd20);
    alloc(5'd5, 4'd11, 1'b0, 6'd20);
    alloc(5'd3, 4'd1, 1'b0, 6'd20);
    dma(16'h8c85, 3'b100, 12'h085);
    dma(16'h9385, 3'b100, 12'h485);
    dma(16'h8d05, 3'b010, 12'h000);
    dma(16'h1234, 3'b001, 12'h000);
    rel_req = 1'b1;
    rel_pnr = 5'd3;
    @(negedge ref_clk);
    rel_req = 1'b0;
    check(free_pages, 20'd22);
    dma(16'h8c85, 3'b010, 12'h000);
    dma_valid = 1'b0;
    $display("dma test done");
  endtask : test_dma
  // Transmit queue of one endpoint: fills at five, sixth ignored
  task automatic test_queues();
    tx_ep   = 4'h5;
    tx_push = 1'b1;
    repeat (6) @(negedge ref_clk);
    tx_push = 1'b0;
    check(tx_full, 20'h00020);
    tx_pop = 1'b1;
    @(negedge ref_clk);
    tx_pop = 1'b0;
    check(tx_full, 20'h00000);
    $display("queue test done");
  endtask : test_queues
  // One buffer access by requester r, held until its grant
  task automatic buf_op(input int r, input logic we, input logic [11:0] a,
                        input logic [7:0] wd, input logic [7:0] exp);
    buf_req[r]           = 1'b1;
    buf_we[r]            = we;
    buf_addr[12*r +: 12] = a;
    buf_wdata[8*r +: 8]  = wd;
    @(negedge ref_clk);
    for (int i = 0; i < 20 && !buf_gnt[r]; i++) @(negedge ref_clk);
    buf_req[r] = 1'b0;
    check(buf_gnt[r], 20'h1);
    if (!we) check(buf_rdata, exp);
  endtask : buf_op
  // Received packets: header, notify, queue fill and back-off
  task automatic test_rx();
    rx_pnr   = 5'd4;
    rx_frame = 11'h5a3;
    rx_ep    = 4'h6;
    for (int k = 0; k < 17; k++) begin
      rx_done  = 1'b1;
      rx_bytes = 11'h040 + 11'(k);
      @(negedge ref_clk);
      rx_done = 1'b0;
      for (int i = 0; i < 60 && !rx_arrived; i++) @(negedge ref_clk);
      check(rx_arrived, 20'h1);
    end
    check({rx_backoff, rx_count}, 20'h30);
    rx_pop = 1'b1;
    @(negedge ref_clk);
    rx_pop = 1'b0;
    check({rx_backoff, rx_count}, 20'h0f);
    buf_op(0, 1'b0, 12'h100, 8'h00, 8'ha3);
    buf_op(1, 1'b0, 12'h101, 8'h00, 8'h35);
    buf_op(2, 1'b0, 12'h102, 8'h00, 8'h50);
    buf_op(3, 1'b1, 12'h7ff, 8'hc4, 8'h00);
    buf_op(4, 1'b0, 12'h7ff, 8'h00, 8'hc4);
    $display("receive test done");
  endtask : test_rx
  // Reset for five cycles, then every scenario and the verdict
  initial begin
    {reset_n, dma_valid, dma_addr, alloc_req, alloc_pnr, alloc_len} = '0;
    {rel_req, rel_pnr, tx_push, tx_pop, tx_ep, rx_pop, rx_done} = '0;
    {rx_pnr, rx_frame, rx_ep, rx_bytes, buf_req, buf_we} = '0;
    {buf_addr, buf_wdata} = '0;
    repeat (5) @(negedge ref_clk);
    reset_n = 1'b1;
    test_decode();
    test_dma();
    test_queues();
    test_rx();
    results();
  end
  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    num_errors++;
    results();
  end
endmodule : bamd_top_bench
